// File: rtl/sbarb_top.sv
// secondary bus arbiter with internal/external arbitration mode
`timescale 1ns/1ps
`default_nettype none
// Function
// - nine active-low request inputs, 8 down to 0, each contend for the bus.
// - each request input is placed in the high or low rotating group by a group bit.
// - the next owner is chosen by two-level rotating priority, fair within each group.
// - at most one grant is asserted at a time and a master starts only on an idle bus.
// - strap low enables the internal arbiter; strap high disables it for an external one.
// - in external mode request 0 is the bridge grant, usable only with an idle bus.
// - in external mode grant 0 is the bridge request output.
// - in external mode with grant in, idle bus and no work, the bridge parks the bus.
module sbarb_top (
  input  wire logic       i_mclk,
  input  wire logic       i_arst_n,
  input  wire logic [8:0] i_req_n,
  input  wire logic       i_cfn_n,
  input  wire logic       i_bus_idle,
  input  wire logic [8:0] i_grp_high,
  input  wire logic       i_own_req,
  output logic      [8:0] o_gnt_n,
  output logic            o_own_gnt,
  output logic            o_own_start,
  output logic            o_park
);
  import sbarb_pkg::*;
  // ****************************************
  // input synchronisers
  // ****************************************
  logic [8:0] rq_s1, rq_s2, rq_s3;
  logic       cf_s1, cf_s2, cf_s3;
  logic [8:0] req_sync;
  logic       ext_mode;
  logic [8:0] next_req_sync;
  logic       next_ext_mode;
  always_comb begin
    next_req_sync = req_sync;
    next_ext_mode = ext_mode;
    // a change counts once the second and third stage agree, so a glitch on one edge is ignored
    for (int b = 0; b < SBARB_NREQ; b++) begin
      if (rq_s2[b] == rq_s3[b]) begin
        next_req_sync[b] = rq_s3[b];
      end
    end
    if (cf_s2 == cf_s3) begin
      next_ext_mode = cf_s3;
    end
  end
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rq_s1    <= SBARB_IDLE_N;
      rq_s2    <= SBARB_IDLE_N;
      rq_s3    <= SBARB_IDLE_N;
      req_sync <= SBARB_IDLE_N;
      cf_s1    <= 1'b0;
      cf_s2    <= 1'b0;
      cf_s3    <= 1'b0;
      ext_mode <= 1'b0;
    end else begin
      rq_s1 <= i_req_n;
      rq_s2 <= rq_s1;
      rq_s3 <= rq_s2;
      cf_s1 <= i_cfn_n;
      cf_s2 <= cf_s1;
      cf_s3    <= cf_s2;
      req_sync <= next_req_sync;
      ext_mode <= next_ext_mode;
    end
  end
  // ****************************************
  // arbitration
  // ****************************************
  logic [9:0] req_act;
  logic [9:0] req_hi;
  logic [9:0] req_lo;
  logic [8:0] grp;
  logic [3:0] ptr_hi, ptr_lo, next_ptr_hi, next_ptr_lo;
  logic [3:0] owner, next_owner;
  sbarb_state_type state, next_state;
  logic [8:0] next_gnt_n;
  logic next_own_gnt, next_own_start, next_park;
  sbarb_sel_if sel_hi();
  sbarb_sel_if sel_lo();
  sbarb_pick u_pick_hi (.s(sel_hi.pick));
  sbarb_pick u_pick_lo (.s(sel_lo.pick));
  assign grp     = i_grp_high;
  assign req_act = {i_own_req, ~req_sync};
  always_comb begin
    req_lo = '0;
    req_hi = '0;
    for (int b = 0; b < SBARB_NREQ; b++) begin
      req_lo[b] = req_act[b] & ~grp[b];
      req_hi[b] = req_act[b] & grp[b];
    end
    req_lo[SBARB_SLOT_OWN] = 1'b0;
    // own request rides in the high group; the low group shares slot 9 with it
    req_hi[SBARB_SLOT_LOW] = req_act[SBARB_SLOT_OWN] | (|req_lo);
  end
  assign sel_hi.req = req_hi;
  assign sel_hi.ptr = ptr_hi;
  assign sel_lo.req = req_lo;
  assign sel_lo.ptr = ptr_lo;
  always_comb begin
    next_state     = state;
    next_owner     = owner;
    next_ptr_hi    = ptr_hi;
    next_ptr_lo    = ptr_lo;
    next_gnt_n     = SBARB_IDLE_N;
    next_own_gnt   = 1'b0;
    next_own_start = 1'b0;
    next_park      = 1'b0;
    case (state)
      SBARB_ST_IDLE, SBARB_ST_GRANT: begin
        if (ext_mode) begin
          next_state = SBARB_ST_EXT;
        end else if (sel_hi.found) begin
          next_state  = SBARB_ST_GRANT;
          next_ptr_hi = sel_hi.win;
          if (sel_hi.win == SBARB_SLOT_LOW && !i_own_req) begin
            next_owner  = sel_lo.win;
            next_ptr_lo = sel_lo.win;
          end else begin
            next_owner = sel_hi.win;
          end
        end else begin
          // nobody asks: park on the bridge itself
          next_state = SBARB_ST_IDLE;
          next_owner = SBARB_SLOT_OWN;
        end
        if (!ext_mode) begin
          for (int b = 0; b < SBARB_NREQ; b++) begin
            next_gnt_n[b] = !(next_owner == SBARB_PW'(b));
          end
          next_own_gnt   = (next_owner == SBARB_SLOT_OWN);
          next_own_start = next_own_gnt & i_own_req & i_bus_idle;
          next_park      = next_own_gnt & ~i_own_req & i_bus_idle;
        end
      end
      SBARB_ST_EXT: begin
        if (!ext_mode) begin
          next_state = SBARB_ST_IDLE;
        end
        next_gnt_n[0]  = ~i_own_req;
        next_own_gnt   = ~req_sync[0];
        next_own_start = ~req_sync[0] & i_bus_idle & i_own_req;
        next_park      = ~req_sync[0] & i_bus_idle & ~i_own_req;
      end
      default: next_state = SBARB_ST_IDLE;
    endcase
  end
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state       <= SBARB_ST_IDLE;
      owner       <= SBARB_SLOT_OWN;
      ptr_hi      <= SBARB_PTR_RST;
      ptr_lo      <= SBARB_PTR_RST;
      o_gnt_n     <= SBARB_IDLE_N;
      o_own_gnt   <= 1'b0;
      o_own_start <= 1'b0;
      o_park      <= 1'b0;
    end else begin
      state       <= next_state;
      owner       <= next_owner;
      ptr_hi      <= next_ptr_hi;
      ptr_lo      <= next_ptr_lo;
      o_gnt_n     <= next_gnt_n;
      o_own_gnt   <= next_own_gnt;
      o_own_start <= next_own_start;
      o_park      <= next_park;
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  property p_one_grant;
    @(posedge i_mclk) disable iff (!i_arst_n) $countones(~o_gnt_n) <= 1;
  endproperty
  a_one_grant: assert property (p_one_grant) else $error("more than one grant");
  property p_start_idle;
    @(posedge i_mclk) disable iff (!i_arst_n) o_own_start |-> $past(i_bus_idle);
  endproperty
  a_start_idle: assert property (p_start_idle) else $error("start on busy bus");
  property p_ext_req;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (state == SBARB_ST_EXT && ext_mode) |=> (o_gnt_n[0] == !$past(i_own_req));
  endproperty
  a_ext_req: assert property (p_ext_req) else $error("ext request wrong");
  property p_ext_park;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (state == SBARB_ST_EXT && !req_sync[0] && i_bus_idle && !i_own_req) |=> o_park;
  endproperty
  a_ext_park: assert property (p_ext_park) else $error("no park");
  property p_ext_start;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (state == SBARB_ST_EXT && req_sync[0]) |=> !o_own_start;
  endproperty
  a_ext_start: assert property (p_ext_start) else $error("start without grant");
  property p_rotate;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (!ext_mode && state != SBARB_ST_EXT && sel_hi.found) |=> ptr_hi == $past(sel_hi.win);
  endproperty
  a_rotate: assert property (p_rotate) else $error("pointer not advanced");
  property p_ext_gnt;
    @(posedge i_mclk) disable iff (!i_arst_n) (state == SBARB_ST_EXT) |=> o_gnt_n[8:1] == 8'hFF;
  endproperty
  a_ext_gnt: assert property (p_ext_gnt) else $error("grant in ext mode");
  property p_grant_req;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (!ext_mode && state != SBARB_ST_EXT && sel_hi.found && sel_hi.win != SBARB_SLOT_LOW)
        |=> !o_gnt_n[$past(sel_hi.win)] || $past(sel_hi.win) == SBARB_SLOT_OWN;
  endproperty
  a_grant_req: assert property (p_grant_req) else $error("winner not granted");
  property p_low_slot;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (|req_lo && !i_own_req) |-> req_hi[SBARB_SLOT_LOW];
  endproperty
  a_low_slot: assert property (p_low_slot) else $error("low slot missing");
  property p_park_int;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (!ext_mode && state != SBARB_ST_EXT && !sel_hi.found && i_bus_idle) |=> o_park && o_own_gnt;
  endproperty
  a_park_int: assert property (p_park_int) else $error("idle bus not parked on bridge");
  property p_start_gnt;
    @(posedge i_mclk) disable iff (!i_arst_n) o_own_start |-> o_own_gnt;
  endproperty
  a_start_gnt: assert property (p_start_gnt) else $error("start without own grant");
endmodule
`default_nettype wire

// File: rtl/sbarb_pkg.sv
// package of constants and types for the secondary bus arbiter
package sbarb_pkg;
  localparam int          SBARB_NREQ     = 9;
  localparam int          SBARB_NSLOT    = 10;
  localparam int          SBARB_PW       = 4;
  localparam logic [SBARB_PW-1:0] SBARB_PTR_RST  = 4'h0;
  localparam logic [SBARB_PW-1:0] SBARB_SLOT_LOW = 4'h9;
  localparam logic [SBARB_PW-1:0] SBARB_SLOT_OWN = 4'h9;
  localparam logic [8:0]  SBARB_IDLE_N   = 9'h1FF;
  localparam logic [8:0]  SBARB_GRP_RST  = 9'h000;
  typedef enum logic [1:0] {
    SBARB_ST_IDLE,
    SBARB_ST_GRANT,
    SBARB_ST_EXT
  } sbarb_state_type;
endpackage

// File: rtl/sbarb_sel_if.sv
// interface carrying one rotating selection between pick and arbiter
`timescale 1ns/1ps
`default_nettype none
interface sbarb_sel_if;
  logic [9:0] req;
  logic [3:0] ptr;
  logic       found;
  logic [3:0] win;
  modport user (output req, output ptr, input found, input win);
  modport pick (input req, input ptr, output found, output win);
endinterface
`default_nettype wire

// File: rtl/sbarb_pick.sv
// rotating picker: first request after the pointer, wrapping round
`timescale 1ns/1ps
`default_nettype none
module sbarb_pick (
  sbarb_sel_if.pick s
);
  import sbarb_pkg::*;
  always_comb begin
    int k;
    int idx;
    k       = 0;
    idx     = 0;
    s.found = 1'b0;
    s.win   = SBARB_PTR_RST;
    for (k = 1; k <= SBARB_NSLOT; k++) begin
      idx = (int'(s.ptr) + k) % SBARB_NSLOT;
      if (!s.found && s.req[idx]) begin
        s.found = 1'b1;
        s.win   = SBARB_PW'(idx);
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/sbarb_masters.sv
// secondary bus masters (or external arbiter) driving the request lines
`timescale 1ns/1ps
`default_nettype none
module sbarb_masters (
  input  wire logic       i_mclk,
  input  wire logic [8:0] i_want,
  output logic      [8:0] o_req_n
);
  // **************************************
  // request lines, held low while wanted
  // **************************************
  initial o_req_n = 9'h1FF;
  // line 0 doubles as the grant from an external arbiter in strap-high mode
  always @(posedge i_mclk) o_req_n <= #1 ~i_want;
endmodule
`default_nettype wire

// File: tb/sbarb_tb_top.sv
// self-checking bench for the secondary bus arbiter
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module sbarb_tb_top;
  import sbarb_pkg::*;
  logic       i_mclk = 0, i_arst_n = 0, i_cfn_n = 0, i_bus_idle = 1, i_own_req = 0;
  logic [8:0] want = 0, i_grp_high = 9'h1FF, req_n, o_gnt_n, w, g;
  logic       o_own_gnt, o_own_start, o_park;
  int         err_total = 0, samples_checked = 0, cyc = 0;
  int         cnt[10];
  always #50 i_mclk = ~i_mclk;
  sbarb_masters mst_u (.i_mclk(i_mclk), .i_want(want), .o_req_n(req_n));
  sbarb_top dut_u (.i_mclk, .i_arst_n, .i_req_n(req_n), .i_cfn_n, .i_bus_idle, .i_grp_high,
    .i_own_req, .o_gnt_n, .o_own_gnt, .o_own_start, .o_park);
  // ******************************
  // tasks
  // ******************************
  task automatic step(int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic rst(logic cfn);
    i_arst_n = 0; i_cfn_n = cfn; want = 0; i_own_req = 0;
    step(20);
    `CHK(o_gnt_n, SBARB_IDLE_N)
    i_arst_n = 1;
    step(8);
  endtask
  // model: rotation over slots 0..9, slot 9 is the bridge (first claim) or else the low group,
  // which rotates on its own inside that slot; the winner becomes lowest next time
  task automatic arb(logic [8:0] wv, logic [8:0] gv, logic own);
    int n, m, s, nn, prv, lol, es, el, x, os;
    logic [9:0] sr, wq;
    logic [8:0] lr;
    want = wv; i_grp_high = gv; i_own_req = own; step(8);
    n = $countones(wv & gv); m = $countones(wv & ~gv);
    s = n + (m > 0 || own); nn = s * (m > 0 ? m : 1) * 2;
    sr = {m > 0 || own, wv & gv}; lr = wv & ~gv; wq = {own, wv};
    cnt = '{default:0}; prv = -1; lol = -1;
    repeat (nn) begin
      step(1);
      `CHK($countones(~o_gnt_n) + o_own_gnt, 1)
      x = 9;
      for (int k = 0; k < 9; k++) if (o_gnt_n[k] === 1'b0) x = k;
      cnt[x]++;
      `CHK(wq[x], 1'b1)
      `CHK(o_own_start, x == 9 && own && i_bus_idle)
      os = (x < 9 && gv[x]) ? x : 9;
      if (prv >= 0) begin
        es = -1;
        for (int d = 1; d <= 10; d++) if (es < 0 && sr[(prv + d) % 10]) es = (prv + d) % 10;
        `CHK(os, es)
        if (es == 9 && !own && lol >= 0) begin
          el = -1;
          for (int d = 1; d <= 9; d++) if (el < 0 && lr[(lol + d) % 9]) el = (lol + d) % 9;
          `CHK(x, el)
        end
      end
      if (os == 9 && x < 9) lol = x;
      prv = os;
    end
    for (int k = 0; k < 9; k++) if (wv[k]) `CHK(cnt[k], gv[k] ? nn / s : (own ? 0 : nn / (s * m)))
    if (own) `CHK(cnt[9], nn / s)
  endtask
  always @(posedge i_mclk) begin
    cyc++;
    // a hang costs at most a few ms of simulated time
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(32'hA049));
    rst(1'b0);
    for (int c = 0; c < 4; c++) begin
      i_own_req = c[0]; i_bus_idle = c[1]; step(6);
      `CHK({o_own_gnt, o_own_start, o_park}, {1'b1, c[0] & c[1], !c[0] & c[1]})
    end
    i_own_req = 0;
    $display("test bridge_only done");
    for (int k = 0; k < 9; k++) arb(9'h001 << k, 9'($urandom), 1'b0);
    $display("test single done");
    for (int i = 0; i < 14; i++) begin
      w = 9'($urandom); g = 9'($urandom);
      if (w == 9'h000) w = 9'h101;
      arb(w, g, 1'($urandom));
    end
    $display("test random_groups done");
    rst(1'b1);
    for (int i = 0; i < 12; i++) begin
      w = 9'($urandom); i_own_req = w[1]; i_bus_idle = w[2]; want = w; step(8);
      `CHK(o_gnt_n, {8'hFF, ~w[1]})
      `CHK({o_own_gnt, o_own_start}, {w[0], w[0] & w[2] & w[1]})
      `CHK(o_park, w[0] & w[2] & ~w[1])
    end
    $display("test external done");
    wrap_up();
  end
endmodule
`default_nettype wire
